// [src/phyx_defines.svh]
// offsets, field positions and reset values of the extended control registers
`ifndef PHYX_DEFINES_SVH
`define PHYX_DEFINES_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define PHYX_ADDR_W 6
`define PHYX_REG_EXT_A 6'h13
`define PHYX_REG_EXT_B 6'h14
`define PHYX_NATIVE_LAST 6'h25
`define PHYX_BASE_LAST 6'h13

// ----------------------------------------------------------------
// extended_control_a fields
// ----------------------------------------------------------------
`define PHYX_A_NODE 15
`define PHYX_A_SPEED_SRC 14
`define PHYX_A_REMOTE_FAULT 13
`define PHYX_A_BANK_HI 12
`define PHYX_A_BANK_LO 11
`define PHYX_A_RSVD_RO 10
`define PHYX_A_XOVER_AUTO 9
`define PHYX_A_PAIR_MANUAL 8
`define PHYX_A_FLOAT 7
`define PHYX_A_AUTO_PD 0
`define PHYX_A_RESET 16'h0201
`define PHYX_A_WMASK 16'hdbff

// ----------------------------------------------------------------
// extended_control_b fields
// ----------------------------------------------------------------
`define PHYX_B_DRIVE_BOOST 15
`define PHYX_B_RESET 16'h3fe9

// ----------------------------------------------------------------
// bank codes
// ----------------------------------------------------------------
`define PHYX_BANK_LEGACY 2'b01
`define PHYX_BANK_NATIVE 2'b00

`endif

// [src/phyx_pkg.sv]
// types shared by the extended control register logic
package phyx_pkg;

    // ----------------------------------------------------------------
    // management access request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } phyx_req_s;

    // ----------------------------------------------------------------
    // pin synchroniser state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic meta_q;
        logic sync_q;
    } phyx_sync_s;

    // ----------------------------------------------------------------
    // register bank state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ext_a_q;
        logic [15:0] ext_b_q;
        logic [15:0] rdata_q;
        logic rvalid_q;
        logic hit_q;
        logic speed_100_q;
        logic tx_float_q;
        logic tx100_pwrdn_q;
        logic xover_auto_q;
        logic pair_manual_q;
        logic drive_boost_q;
        logic legacy_bank_q;
    } phyx_state_s;

endpackage

// [src/phyx_pin_sync.sv]
// two-flop synchroniser for the speed strap pin
`timescale 1ns/100ps
module phyx_pin_sync
    import phyx_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic sync_o
);

    phyx_sync_s st_q;
    phyx_sync_s st_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.meta_q = pin_i;
        st_d.sync_q = st_q.meta_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.sync_q;

endmodule

// [src/phyx_ext_ctrl.sv]
// extended control registers: node mode, speed source, bank, pairs, drivers
`timescale 1ns/100ps
`include "phyx_defines.svh"
module phyx_ext_ctrl
    import phyx_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic MGMT_WR_I,
    input wire logic MGMT_RD_I,
    input wire logic [5:0] MGMT_ADDR_I,
    input wire logic [15:0] MGMT_WDATA_I,
    output logic [15:0] MGMT_RDATA_O,
    output logic MGMT_RVALID_O,
    output logic MGMT_HIT_O,
    input wire logic BASIC_SPEED_100_I,
    input wire logic SPEED_PIN_I,
    input wire logic REMOTE_FAULT_I,
    input wire logic NO_SIGNAL_I,
    output logic SPEED_100_O,
    output logic TX_FLOAT_O,
    output logic TX100_PWRDN_O,
    output logic CROSSOVER_AUTO_ENABLE_O,
    output logic MANUAL_PAIR_ASSIGNMENT_O,
    output logic DRIVE_BOOST_O,
    output logic LEGACY_BANK_O
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_legacy(input logic [1:0] bank);
        is_legacy = (bank == `PHYX_BANK_LEGACY);
    endfunction

    function automatic logic sel_a(input logic [5:0] addr);
        sel_a = (addr == `PHYX_REG_EXT_A);
    endfunction

    // register b exists in every bank code except legacy; a is a base register
    function automatic logic sel_b(input logic [5:0] addr, input logic [1:0] bank);
        sel_b = (addr == `PHYX_REG_EXT_B) && !is_legacy(bank);
    endfunction

    // any address this bank answers for at all
    function automatic logic in_bank(input logic [5:0] addr, input logic [1:0] bank);
        if (is_legacy(bank))
        begin
            in_bank = (addr <= `PHYX_BASE_LAST);
        end
        else
        begin
            in_bank = (addr <= `PHYX_NATIVE_LAST);
        end
    endfunction

    // ----------------------------------------------------------------
    // register images
    // ----------------------------------------------------------------
    localparam logic [15:0] a_reset_word = `PHYX_A_RESET;
    localparam logic [15:0] b_reset_word = `PHYX_B_RESET;
    localparam logic [15:0] a_write_mask = `PHYX_A_WMASK;

    // read-only bits of a keep their stored value on a write
    function automatic logic [15:0] merge_a(
        input logic [15:0] old_word,
        input logic [15:0] new_word
    );
        merge_a = (new_word & a_write_mask) | (old_word & ~a_write_mask);
    endfunction

    // word returned for an index; unbacked indices read as zero
    function automatic logic [15:0] read_word(
        input logic [5:0] addr,
        input logic [1:0] bank,
        input logic [15:0] a_word,
        input logic [15:0] b_word
    );
        if (sel_a(addr))
        begin
            read_word = a_word;
        end
        else if (sel_b(addr, bank))
        begin
            read_word = b_word;
        end
        else
        begin
            read_word = '0;
        end
    endfunction

    // derived outputs start from the register reset words; speed and power-down start at zero
    function automatic phyx_state_s reset_state();
        phyx_state_s s;
        s = '0;
        s.ext_a_q = a_reset_word;
        s.ext_b_q = b_reset_word;
        s.xover_auto_q = a_reset_word[`PHYX_A_XOVER_AUTO];
        s.pair_manual_q = a_reset_word[`PHYX_A_PAIR_MANUAL];
        s.tx_float_q = a_reset_word[`PHYX_A_FLOAT];
        s.drive_boost_q = b_reset_word[`PHYX_B_DRIVE_BOOST];
        s.legacy_bank_q = is_legacy(a_reset_word[`PHYX_A_BANK_HI:`PHYX_A_BANK_LO]);
        reset_state = s;
    endfunction

    // ----------------------------------------------------------------
    // speed pin synchroniser
    // ----------------------------------------------------------------
    logic speed_pin_sync;

    phyx_pin_sync u_speed_sync (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .pin_i(SPEED_PIN_I),
        .sync_o(speed_pin_sync)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phyx_state_s st_q;
    phyx_state_s st_d;
    phyx_req_s req;
    logic [1:0] bank;
    logic [15:0] a_view;

    assign req.wr = MGMT_WR_I;
    assign req.rd = MGMT_RD_I;
    assign req.addr = MGMT_ADDR_I;
    assign req.wdata = MGMT_WDATA_I;
    assign bank = st_q.ext_a_q[`PHYX_A_BANK_HI:`PHYX_A_BANK_LO];

    // read view: live fault bit, reserved read-only bit as zero
    always_comb
    begin
        a_view = st_q.ext_a_q;
        a_view[`PHYX_A_REMOTE_FAULT] = REMOTE_FAULT_I;
        a_view[`PHYX_A_RSVD_RO] = 1'b0;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rvalid_q = 1'b0;
        st_d.hit_q = 1'b0;
        // register writes; read-only bits masked off
        if (req.wr && sel_a(req.addr))
        begin
            // reserved read-only bit keeps its stored value, not the manager's write
            st_d.ext_a_q = merge_a(st_q.ext_a_q, req.wdata);
        end
        if (req.wr && sel_b(req.addr, bank))
        begin
            st_d.ext_b_q = req.wdata;
        end
        // reads answer one cycle later
        if (req.rd)
        begin
            st_d.rvalid_q = 1'b1;
            st_d.hit_q = in_bank(req.addr, bank);
            st_d.rdata_q = read_word(req.addr, bank, a_view, st_q.ext_b_q);
        end
        // node bit is only stored; no repeater path exists
        if (st_q.ext_a_q[`PHYX_A_SPEED_SRC])
        begin
            st_d.speed_100_q = speed_pin_sync;
        end
        else
        begin
            st_d.speed_100_q = BASIC_SPEED_100_I;
        end
        st_d.tx_float_q = st_q.ext_a_q[`PHYX_A_FLOAT];
        st_d.tx100_pwrdn_q = st_q.ext_a_q[`PHYX_A_AUTO_PD] && NO_SIGNAL_I;
        st_d.xover_auto_q = st_q.ext_a_q[`PHYX_A_XOVER_AUTO];
        st_d.pair_manual_q = st_q.ext_a_q[`PHYX_A_PAIR_MANUAL];
        st_d.drive_boost_q = st_q.ext_b_q[`PHYX_B_DRIVE_BOOST];
        st_d.legacy_bank_q = is_legacy(bank);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            st_q <= reset_state();
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign MGMT_RDATA_O = st_q.rdata_q;
    assign MGMT_RVALID_O = st_q.rvalid_q;
    assign MGMT_HIT_O = st_q.hit_q;
    assign SPEED_100_O = st_q.speed_100_q;
    assign TX_FLOAT_O = st_q.tx_float_q;
    assign TX100_PWRDN_O = st_q.tx100_pwrdn_q;
    assign CROSSOVER_AUTO_ENABLE_O = st_q.xover_auto_q;
    assign MANUAL_PAIR_ASSIGNMENT_O = st_q.pair_manual_q;
    assign DRIVE_BOOST_O = st_q.drive_boost_q;
    assign LEGACY_BANK_O = st_q.legacy_bank_q;

endmodule

// [tb/phyx_ext_ctrl_properties.sv]
// concurrent checks on the extended control register ports
`timescale 1ns/100ps
module phyx_ext_ctrl_properties
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic MGMT_WR_I,
    input wire logic MGMT_RD_I,
    input wire logic [5:0] MGMT_ADDR_I,
    input wire logic [15:0] MGMT_WDATA_I,
    input wire logic [15:0] MGMT_RDATA_O,
    input wire logic MGMT_RVALID_O,
    input wire logic MGMT_HIT_O,
    input wire logic BASIC_SPEED_100_I,
    input wire logic SPEED_PIN_I,
    input wire logic REMOTE_FAULT_I,
    input wire logic NO_SIGNAL_I,
    input wire logic SPEED_100_O,
    input wire logic TX_FLOAT_O,
    input wire logic TX100_PWRDN_O,
    input wire logic CROSSOVER_AUTO_ENABLE_O,
    input wire logic MANUAL_PAIR_ASSIGNMENT_O,
    input wire logic DRIVE_BOOST_O,
    input wire logic LEGACY_BANK_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    logic [15:0] sa_q, sb_q;
    logic [2:0] rs_q;
    logic wa, wb;
    assign wa = MGMT_WR_I && MGMT_ADDR_I == 6'h13;
    assign wb = MGMT_WR_I && MGMT_ADDR_I == 6'h14 && sa_q[12:11] != 2'b01;
    always_ff @(posedge CLK_I)
    begin
        rs_q <= {rs_q[1:0], RESET_I};
        sa_q <= RESET_I ? 16'h0201 : wa ? sa_q & ~16'hdbff | MGMT_WDATA_I & 16'hdbff : sa_q;
        sb_q <= RESET_I ? 16'h3fe9 : wb ? MGMT_WDATA_I : sb_q;
    end
    speed_reg_a: assert property (rs_q == 3'h0 && !$past(sa_q[14])
        |-> SPEED_100_O == $past(BASIC_SPEED_100_I)) else $error("speed not from bit");
    speed_pin_a: assert property (rs_q == 3'h0 && $past(sa_q[14])
        |-> SPEED_100_O == $past(SPEED_PIN_I, 3)) else $error("speed not from pin");
    bank_hit_a: assert property (MGMT_RVALID_O && rs_q == 3'h0 |-> MGMT_HIT_O ==
        ($past(MGMT_ADDR_I) <= ($past(sa_q[12:11]) == 2'b01 ? 6'h13 : 6'h25))) else $error("bad hit");
    read_back_a: assert property (MGMT_RVALID_O && $past(MGMT_ADDR_I) == 6'h13 |->
        MGMT_RDATA_O == ($past(sa_q) | 16'($past(REMOTE_FAULT_I)) << 13)) else $error("bad read");
    cross_pair_a: assert property (rs_q == 3'h0 |->
        {CROSSOVER_AUTO_ENABLE_O, MANUAL_PAIR_ASSIGNMENT_O} == $past(sa_q[9:8])) else $error("bad pair");
    line_float_a: assert property (rs_q == 3'h0 |-> TX_FLOAT_O == $past(sa_q[7]))
        else $error("bad float");
    auto_pwrdn_a: assert property (rs_q == 3'h0 |->
        TX100_PWRDN_O == $past(sa_q[0] && NO_SIGNAL_I)) else $error("bad power down");
    drive_boost_a: assert property (rs_q == 3'h0 |-> DRIVE_BOOST_O == $past(sb_q[15]))
        else $error("bad boost");
    legacy_bank_a: assert property (rs_q == 3'h0 |->
        LEGACY_BANK_O == ($past(sa_q[12:11]) == 2'b01)) else $error("bad bank flag");
    cover property (MGMT_RVALID_O && LEGACY_BANK_O && !MGMT_HIT_O);
    cover property (MGMT_WR_I && MGMT_ADDR_I == 6'h14 && !wb);
    cover property (rs_q == 3'h0 && sa_q[14] && SPEED_100_O);
    cover property (TX100_PWRDN_O && TX_FLOAT_O);
endmodule
bind phyx_ext_ctrl phyx_ext_ctrl_properties chk_u (.*);

// [tb/phyx_mgmt_model.sv]
// management entity model driving the register port
`timescale 1ns/100ps
module phyx_mgmt_model
(
    input wire logic clk_i,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [5:0] addr_o = 6'h2a,
    output logic [15:0] wdata_o = 16'h5a5a
);
    task automatic access(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
        @(negedge clk_i);
        // released lines show no stale value
        {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    endtask
endmodule

// [tb/phyx_ext_ctrl_tb_top.sv]
// self-checking bench for the extended control registers
`timescale 1ns/100ps
module phyx_ext_ctrl_tb_top;
    logic CLK_I, RESET_I, MGMT_WR_I, MGMT_RD_I, MGMT_RVALID_O, MGMT_HIT_O, SPEED_100_O;
    logic BASIC_SPEED_100_I, SPEED_PIN_I, REMOTE_FAULT_I, NO_SIGNAL_I, TX_FLOAT_O;
    logic TX100_PWRDN_O, CROSSOVER_AUTO_ENABLE_O, MANUAL_PAIR_ASSIGNMENT_O;
    logic DRIVE_BOOST_O, LEGACY_BANK_O;
    logic [5:0] MGMT_ADDR_I;
    logic [15:0] MGMT_WDATA_I, MGMT_RDATA_O, sa, sb, v;
    logic [16:0] exp_q[$];
    logic [16:0] e_note;
    logic [6:0] st_got, st_exp;
    int mismatches = 0, check_count = 0;
    phyx_ext_ctrl dut_u (.*);
    phyx_mgmt_model mdl_u (.clk_i(CLK_I), .wr_o(MGMT_WR_I), .rd_o(MGMT_RD_I),
        .addr_o(MGMT_ADDR_I), .wdata_o(MGMT_WDATA_I));
    initial
    begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    task automatic cmp_read(input logic [16:0] g, input logic [16:0] e);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error t=%0t read got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_status(input logic [6:0] g, input logic [6:0] e);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error t=%0t status got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [5:0] a);
        logic lg;
        lg = sa[12:11] == 2'b01;
        exp_q.push_back({a <= (lg ? 6'h13 : 6'h25),
            a == 6'h13 ? sa | 16'(REMOTE_FAULT_I) << 13 : a == 6'h14 && !lg ? sb : 16'h0});
        mdl_u.access(1'b0, a, 16'h0);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        if (a == 6'h13)
            sa = sa & ~16'hdbff | d & 16'hdbff;
        else if (sa[12:11] != 2'b01)
            sb = d;
        mdl_u.access(1'b1, a, d);
    endtask
    task automatic final_report;
        if (exp_q.size() != 0)
        begin
            mismatches++;
            $display("Error t=%0t reads pending %h exp %h", $time, exp_q.size(), 0);
        end
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(negedge CLK_I)
        if (MGMT_RVALID_O === 1'b1)
        begin
            e_note = exp_q.size() > 0 ? exp_q.pop_front() : 17'hx;
            cmp_read({MGMT_HIT_O, MGMT_RDATA_O}, e_note);
        end
    initial
    begin
        {RESET_I, BASIC_SPEED_100_I, SPEED_PIN_I, REMOTE_FAULT_I, NO_SIGNAL_I} = 5'h13;
        {sa, sb} = {16'h0201, 16'h3fe9};
        repeat (6) @(negedge CLK_I);
        RESET_I = 1'b0;
        void'($urandom(51088));
        for (int i = 0; i < 40; i++)
        begin
            v = 16'($urandom);
            {BASIC_SPEED_100_I, SPEED_PIN_I, REMOTE_FAULT_I, NO_SIGNAL_I} = v[3:0];
            rd(6'h13);
            rd(6'h14);
            rd(v[9:4]);
            repeat (3) @(negedge CLK_I);
            st_got = {SPEED_100_O, TX_FLOAT_O, TX100_PWRDN_O, CROSSOVER_AUTO_ENABLE_O,
                MANUAL_PAIR_ASSIGNMENT_O, DRIVE_BOOST_O, LEGACY_BANK_O};
            st_exp = {sa[14] ? SPEED_PIN_I : BASIC_SPEED_100_I, sa[7], sa[0] & NO_SIGNAL_I,
                sa[9:8], sb[15], sa[12:11] == 2'b01};
            cmp_status(st_got, st_exp);
            v = 16'($urandom);
            v[12:11] = 2'(i);
            wr(6'h13, {v[15:7], sa[6:1], v[0]});
            wr(6'h14, {v[15], sb[14:0]});
        end
        final_report;
    end
endmodule
